// ---- rtl/antreg_cfg.svh ----
// offsets, field positions, reset values and identity values of the bank
`ifndef ANTREG_CFG_SVH
`define ANTREG_CFG_SVH
// printed offsets are not all multiples of four: index, byte = 4 * index
`define ANTREG_IDX_TX_LOW 8'h60
`define ANTREG_IDX_TX_HIGH 8'h61
`define ANTREG_IDX_RX_LOW 8'h62
`define ANTREG_IDX_RX_HIGH 8'h63
`define ANTREG_IDX_ROM_VER 8'h70
`define ANTREG_IDX_RAM_MAJ 8'h71
`define ANTREG_IDX_RAM_MIN 8'h72
`define ANTREG_IDX_DEVID_LO 8'h80
`define ANTREG_IDX_DEVID_HI 8'h81
// control and status of the antenna transfers
`define ANTREG_IDX_CTRL 8'h90
`define ANTREG_IDX_STAT 8'h91
`define ANTREG_TX_HIGH_MASK 8'h3f
`define ANTREG_RX_HIGH_MASK 8'h03
`define ANTREG_CTRL_START_BIT 0
`define ANTREG_STAT_DONE_BIT 0
`define ANTREG_STAT_TMO_BIT 1
`define ANTREG_STAT_TXDONE_BIT 2
`define ANTREG_RST_BYTE 8'h00
// identity values are arbitrary
`define ANTREG_ROM_VER 8'h11
`define ANTREG_RAM_MAJ 8'h12
`define ANTREG_RAM_MIN 8'h13
`define ANTREG_DEVID 16'h5a3c
`define ANTREG_RX_BITS 4'd10
`define ANTREG_TX_BITS 4'd14
`endif

// ---- rtl/antreg_pkg.sv ----
// types of the antenna register bank
package antreg_pkg;
  typedef enum logic [1:0] {
    ANTREG_IDLE,
    ANTREG_SEND,
    ANTREG_RECV
  } antreg_state_t;
  typedef logic [7:0] antreg_byte_t;
endpackage

// ---- rtl/antreg_sync.sv ----
// three-stage synchroniser with agreement of last two stages
`timescale 1ns/1ps
module antreg_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end
endmodule

// ---- rtl/antreg_ctl.sv ----
// antenna transfer controller: shifts word out, collects code in
`timescale 1ns/1ps
`include "antreg_cfg.svh"
module antreg_ctl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [13:0] tx_word,
  input wire logic rx_bit,
  input wire logic rx_valid,
  input wire logic rx_end,
  output logic tx_bit,
  output logic busy,
  output logic tx_done,
  output logic rx_done,
  output logic rx_tmo,
  output logic [9:0] rx_code
);
  antreg_pkg::antreg_state_t state_reg;
  logic [13:0] sh_reg;
  logic [3:0] cnt_reg;
  assign busy = (state_reg != antreg_pkg::ANTREG_IDLE);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= antreg_pkg::ANTREG_IDLE;
      sh_reg <= 14'h0000;
      cnt_reg <= 4'h0;
      tx_bit <= 1'b0;
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      rx_tmo <= 1'b0;
      rx_code <= 10'h000;
    end else begin
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      rx_tmo <= 1'b0;
      unique case (state_reg)
        antreg_pkg::ANTREG_IDLE: begin
          cnt_reg <= 4'h0;
          if (start) begin
            sh_reg <= tx_word;
            state_reg <= antreg_pkg::ANTREG_SEND;
          end
        end
        antreg_pkg::ANTREG_SEND: begin
          tx_bit <= sh_reg[13];
          sh_reg <= {sh_reg[12:0], 1'b0};
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == `ANTREG_TX_BITS - 4'd1) begin
            tx_done <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= antreg_pkg::ANTREG_RECV;
          end
        end
        antreg_pkg::ANTREG_RECV: begin
          tx_bit <= 1'b0;
          if (rx_valid) begin
            sh_reg <= {sh_reg[12:0], rx_bit};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (rx_end) begin
            if (cnt_reg == `ANTREG_RX_BITS) begin
              rx_done <= 1'b1;
              rx_code <= sh_reg[9:0];
            end else begin
              rx_tmo <= 1'b1;
            end
            state_reg <= antreg_pkg::ANTREG_IDLE;
          end
        end
        default: state_reg <= antreg_pkg::ANTREG_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/antreg_top.sv ----
// antenna data and identification register bank on AHB-Lite
//
// Notes on behaviour
// - tx word 14 bits, low eight bits in first transmit register
// - tx bits 13:8 in bits 5:0 of second register, 7:6 reserved
// - received code 10 bits, low eight in first receive register
// - rx bits 9:8 in bits 1:0 of second register, 7:2 reserved
// - read-only rom firmware version byte
// - read-only ram firmware major version byte
// - read-only ram firmware minor version byte
// - read-only low byte of device identifier
// - read-only high byte of identifier at next address
// - receive complete only after ten bits, else receive timeout
`timescale 1ns/1ps
`include "antreg_cfg.svh"
module antreg_top (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic ANT_RX_BIT,
  input wire logic ANT_RX_VALID,
  input wire logic ANT_RX_END,
  output logic ANT_TX_BIT
);
  logic [7:0] tx_low_reg;
  logic [5:0] tx_high_reg;
  logic [9:0] rx_code_reg;
  logic start_reg;
  logic done_reg;
  logic tmo_reg;
  logic txdone_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [7:0] rd_next;
  logic rx_bit_s;
  logic rx_valid_s;
  logic rx_end_s;
  logic rx_valid_d_reg;
  logic rx_end_d_reg;
  logic busy;
  logic busy_d_reg;
  logic c_tx_bit;
  logic c_tx_done;
  logic c_rx_done;
  logic c_rx_tmo;
  logic [9:0] c_rx_code;
  logic acc;
  logic [7:0] acc_idx;
  localparam logic [15:0] devid_val = `ANTREG_DEVID;

  // word index of a byte address, aligned words only
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = (a[1:0] == 2'b00 && a[31:10] == 22'h0) ? a[9:2] : 8'hff;
  endfunction

  assign acc = HSEL && HREADY && HTRANS[1];
  assign acc_idx = idx_of(HADDR);

  antreg_sync u_sync_bit (.clk(CLK), .rst_b(RST_B), .d(ANT_RX_BIT),
    .q(rx_bit_s));
  antreg_sync u_sync_valid (.clk(CLK), .rst_b(RST_B), .d(ANT_RX_VALID),
    .q(rx_valid_s));
  antreg_sync u_sync_end (.clk(CLK), .rst_b(RST_B), .d(ANT_RX_END),
    .q(rx_end_s));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_valid_d_reg <= 1'b0;
      rx_end_d_reg <= 1'b0;
      busy_d_reg <= 1'b0;
    end else begin
      rx_valid_d_reg <= rx_valid_s;
      rx_end_d_reg <= rx_end_s;
      busy_d_reg <= busy;
    end
  end

  antreg_ctl u_ctl (
    .clk(CLK),
    .rst_b(RST_B),
    .start(start_reg && !busy && !busy_d_reg),
    .tx_word({tx_high_reg, tx_low_reg}),
    .rx_bit(rx_bit_s),
    .rx_valid(rx_valid_s && !rx_valid_d_reg),
    .rx_end(rx_end_s && !rx_end_d_reg),
    .tx_bit(c_tx_bit),
    .busy(busy),
    .tx_done(c_tx_done),
    .rx_done(c_rx_done),
    .rx_tmo(c_rx_tmo),
    .rx_code(c_rx_code)
  );

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ANT_TX_BIT <= 1'b0;
    end else begin
      ANT_TX_BIT <= c_tx_bit;
    end
  end

  // address phase capture
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else begin
      wr_pend_reg <= acc && HWRITE;
      if (acc) begin
        wr_idx_reg <= acc_idx;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_low_reg <= `ANTREG_RST_BYTE;
      tx_high_reg <= 6'h00;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == `ANTREG_IDX_TX_LOW) begin
        tx_low_reg <= HWDATA[7:0];
      end
      if (wr_idx_reg == `ANTREG_IDX_TX_HIGH) begin
        tx_high_reg <= HWDATA[5:0];
      end
    end
  end

  // received code: host may write, controller fills on completion
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_code_reg <= 10'h000;
    end else if (c_rx_done) begin
      rx_code_reg <= c_rx_code;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == `ANTREG_IDX_RX_LOW) begin
        rx_code_reg[7:0] <= HWDATA[7:0];
      end
      if (wr_idx_reg == `ANTREG_IDX_RX_HIGH) begin
        rx_code_reg[9:8] <= HWDATA[1:0];
      end
    end
  end

  // start set by host, cleared by controller at end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      start_reg <= 1'b0;
    end else if (c_rx_done || c_rx_tmo) begin
      start_reg <= 1'b0;
    end else if (wr_pend_reg && wr_idx_reg == `ANTREG_IDX_CTRL &&
                 HWDATA[`ANTREG_CTRL_START_BIT]) begin
      start_reg <= 1'b1;
    end
  end

  // status flags, set wins over write-one-to-clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      done_reg <= 1'b0;
      tmo_reg <= 1'b0;
      txdone_reg <= 1'b0;
    end else begin
      if (c_rx_done) begin
        done_reg <= 1'b1;
      end else if (wr_pend_reg && wr_idx_reg == `ANTREG_IDX_STAT &&
                   HWDATA[`ANTREG_STAT_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (c_rx_tmo) begin
        tmo_reg <= 1'b1;
      end else if (wr_pend_reg && wr_idx_reg == `ANTREG_IDX_STAT &&
                   HWDATA[`ANTREG_STAT_TMO_BIT]) begin
        tmo_reg <= 1'b0;
      end
      if (c_tx_done) begin
        txdone_reg <= 1'b1;
      end else if (wr_pend_reg && wr_idx_reg == `ANTREG_IDX_STAT &&
                   HWDATA[`ANTREG_STAT_TXDONE_BIT]) begin
        txdone_reg <= 1'b0;
      end
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_next = 8'h00;
    unique case (acc_idx)
      `ANTREG_IDX_TX_LOW: rd_next = tx_low_reg;
      `ANTREG_IDX_TX_HIGH: rd_next = {2'b00, tx_high_reg};
      `ANTREG_IDX_RX_LOW: rd_next = rx_code_reg[7:0];
      `ANTREG_IDX_RX_HIGH: rd_next = {6'h00, rx_code_reg[9:8]};
      `ANTREG_IDX_ROM_VER: rd_next = `ANTREG_ROM_VER;
      `ANTREG_IDX_RAM_MAJ: rd_next = `ANTREG_RAM_MAJ;
      `ANTREG_IDX_RAM_MIN: rd_next = `ANTREG_RAM_MIN;
      `ANTREG_IDX_DEVID_LO: rd_next = devid_val[7:0];
      `ANTREG_IDX_DEVID_HI: rd_next = devid_val[15:8];
      `ANTREG_IDX_CTRL: rd_next = {7'h00, start_reg};
      `ANTREG_IDX_STAT: rd_next = {5'h00, txdone_reg, tmo_reg, done_reg};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (acc && !HWRITE) begin
        HRDATA <= {24'h000000, rd_next};
      end
    end
  end

  tx_rsvd_zero_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    $past(acc && !HWRITE && acc_idx == `ANTREG_IDX_TX_HIGH)
    |-> HRDATA[31:6] == 26'h0)
    else $error("reserved transmit bits read nonzero");
  rx_rsvd_zero_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    $past(acc && !HWRITE && acc_idx == `ANTREG_IDX_RX_HIGH)
    |-> HRDATA[31:2] == 30'h0)
    else $error("reserved receive bits read nonzero");
  tx_low_write_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    wr_pend_reg && wr_idx_reg == `ANTREG_IDX_TX_LOW
    |=> tx_low_reg == $past(HWDATA[7:0]))
    else $error("transmit low byte not stored");
  tx_high_write_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    wr_pend_reg && wr_idx_reg == `ANTREG_IDX_TX_HIGH
    |=> tx_high_reg == $past(HWDATA[5:0]))
    else $error("transmit high bits not stored");
  tx_low_read_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_TX_LOW
    |=> HRDATA == {24'h000000, $past(tx_low_reg)})
    else $error("transmit low byte read wrong");
  rx_low_read_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_RX_LOW
    |=> HRDATA == {24'h000000, $past(rx_code_reg[7:0])})
    else $error("receive low byte read wrong");
  rx_high_read_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_RX_HIGH
    |=> HRDATA[1:0] == $past(rx_code_reg[9:8]))
    else $error("receive high bits read wrong");
  rom_ver_read_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_ROM_VER
    |=> HRDATA == {24'h000000, `ANTREG_ROM_VER})
    else $error("rom version wrong");
  ram_major_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_RAM_MAJ
    |=> HRDATA[7:0] == `ANTREG_RAM_MAJ)
    else $error("ram major version wrong");
  ram_minor_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_RAM_MIN
    |=> HRDATA[7:0] == `ANTREG_RAM_MIN)
    else $error("ram minor version wrong");
  devid_low_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_DEVID_LO
    |=> HRDATA[7:0] == devid_val[7:0])
    else $error("device id low wrong");
  devid_high_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    acc && !HWRITE && acc_idx == `ANTREG_IDX_DEVID_HI
    |=> HRDATA[7:0] == devid_val[15:8])
    else $error("device id high wrong");
  rx_done_code_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    c_rx_done
    |=> done_reg && rx_code_reg == $past(c_rx_code))
    else $error("received code not latched with flag");
  tmo_flag_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    c_rx_tmo
    |=> tmo_reg)
    else $error("timeout flag not raised");
  start_clear_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    (c_rx_done || c_rx_tmo)
    |=> !start_reg)
    else $error("start bit not cleared at end");
  start_hold_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    start_reg && !c_rx_done && !c_rx_tmo
    |=> start_reg)
    else $error("start bit dropped before end");
  flag_excl_a: assert property (@(posedge CLK)
    disable iff (!RST_B)
    !(c_rx_done && c_rx_tmo))
    else $error("complete and timeout together");
endmodule

// ---- testbench/antreg_ant_model.sv ----
// antenna side model: answers with a framed code after a transmit
`timescale 1ns/1ps
module antreg_ant_model (
  input wire logic clk,
  output logic rx_bit,
  output logic rx_valid,
  output logic rx_end
);
  initial begin
    rx_bit = 1'b0;
    rx_valid = 1'b0;
    rx_end = 1'b0;
  end

  task automatic hold(input int c);
    repeat (c) @(posedge clk);
  endtask

  // sends n bits msb first, then the end edge
  task automatic send(input int n, input logic [9:0] code);
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit <= code[i];
      hold(6);
      rx_valid <= 1'b1;
      hold(6);
      rx_valid <= 1'b0;
      // released line shows the inverse, not the old bit
      rx_bit <= ~code[i];
      hold(6);
    end
    rx_end <= 1'b1;
    hold(6);
    rx_end <= 1'b0;
    hold(6);
  endtask
endmodule

// ---- testbench/antreg_tb_top.sv ----
// self-checking bench of the antenna register bank
`timescale 1ns/1ps
`include "antreg_cfg.svh"
module antreg_tb_top;
  localparam logic [15:0] DEVID = `ANTREG_DEVID;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, tx_bit;
  logic rx_bit, rx_valid, rx_end;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [13:0] txw;
  int err_total = 0;
  int check_count = 0;

  antreg_top u_antreg_top (
    .CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .ANT_RX_BIT(rx_bit), .ANT_RX_VALID(rx_valid),
    .ANT_RX_END(rx_end), .ANT_TX_BIT(tx_bit)
  );

  antreg_ant_model u_antreg_ant_model (
    .clk(clk), .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_end(rx_end)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_up(input string nm);
    err_total++;
    $display("[ERR] %s expected done seen timeout", nm);
    close_out();
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) give_up("hready");
  endtask

  // one single word transfer, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] idx,
      input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx,
      input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // first one marks the frame since the word's msb is set
  // sampled mid-cycle, clear of the launching edge
  task automatic grab_tx();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_bit !== 1'b1 && n < 20);
    if (tx_bit !== 1'b1) give_up("tx start");
    txw[13] = 1'b1;
    for (int i = 12; i >= 0; i--) begin
      @(negedge clk);
      txw[i] = tx_bit;
    end
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, `ANTREG_IDX_STAT, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    if (rd[b] !== 1'b1) give_up("status");
  endtask

  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk("tx_low", `ANTREG_IDX_TX_LOW, 8'h00);
    rd_chk("tx_high", `ANTREG_IDX_TX_HIGH, 8'h00);
    rd_chk("rx_low", `ANTREG_IDX_RX_LOW, 8'h00);
    rd_chk("rx_high", `ANTREG_IDX_RX_HIGH, 8'h00);
    wr(`ANTREG_IDX_ROM_VER, 8'hff);
    rd_chk("rom", `ANTREG_IDX_ROM_VER, `ANTREG_ROM_VER);
    rd_chk("ram_maj", `ANTREG_IDX_RAM_MAJ, `ANTREG_RAM_MAJ);
    rd_chk("ram_min", `ANTREG_IDX_RAM_MIN, `ANTREG_RAM_MIN);
    rd_chk("id_lo", `ANTREG_IDX_DEVID_LO, DEVID[7:0]);
    wr(`ANTREG_IDX_DEVID_HI, 8'h00);
    rd_chk("id_hi", `ANTREG_IDX_DEVID_HI, DEVID[15:8]);
    rd_chk("unmapped", 8'h40, 8'h00);
    $display("test ids done");
    wr(`ANTREG_IDX_TX_LOW, 8'ha5);
    wr(`ANTREG_IDX_TX_HIGH, 8'hff);
    wr(`ANTREG_IDX_RX_LOW, 8'h5a);
    wr(`ANTREG_IDX_RX_HIGH, 8'hff);
    rd_chk("tx_low", `ANTREG_IDX_TX_LOW, 8'ha5);
    rd_chk("tx_high", `ANTREG_IDX_TX_HIGH, 8'h3f);
    rd_chk("rx_low", `ANTREG_IDX_RX_LOW, 8'h5a);
    rd_chk("rx_high", `ANTREG_IDX_RX_HIGH, 8'h03);
    $display("test fields done");
    wr(`ANTREG_IDX_TX_LOW, 8'h35);
    wr(`ANTREG_IDX_TX_HIGH, 8'h2c);
    wr(`ANTREG_IDX_CTRL, 8'h01);
    grab_tx();
    chk("tx_word", 32'h2c35, {18'h0, txw});
    rd_chk("ctrl_busy", `ANTREG_IDX_CTRL, 8'h01);
    u_antreg_ant_model.send(10, 10'h2e7);
    poll(`ANTREG_STAT_DONE_BIT);
    rd_chk("stat", `ANTREG_IDX_STAT, 8'h05);
    rd_chk("rx_low", `ANTREG_IDX_RX_LOW, 8'he7);
    rd_chk("rx_high", `ANTREG_IDX_RX_HIGH, 8'h02);
    rd_chk("ctrl_end", `ANTREG_IDX_CTRL, 8'h00);
    wr(`ANTREG_IDX_STAT, 8'h07);
    rd_chk("stat_clr", `ANTREG_IDX_STAT, 8'h00);
    $display("test full transfer done");
    wr(`ANTREG_IDX_CTRL, 8'h01);
    grab_tx();
    chk("tx_word", 32'h2c35, {18'h0, txw});
    u_antreg_ant_model.send(7, 10'h155);
    poll(`ANTREG_STAT_TMO_BIT);
    rd_chk("stat", `ANTREG_IDX_STAT, 8'h06);
    rd_chk("rx_low", `ANTREG_IDX_RX_LOW, 8'he7);
    rd_chk("rx_high", `ANTREG_IDX_RX_HIGH, 8'h02);
    rd_chk("ctrl_end", `ANTREG_IDX_CTRL, 8'h00);
    $display("test short frame done");
    close_out();
  end
endmodule
